/* File: bench/dcsg_panel_model.sv */
// Behavioural model of two smart panels on the asynchronous side.
`timescale 1ns/1ps

module dcsg_panel_model (
    input wire logic i_panel0_select,
    input wire logic i_panel1_select,
    input wire logic [6:0] i_async_pin,
    input wire logic [15:0] i_async_data,
    output logic [15:0] o_word,
    output logic o_panel
);
    // A panel latches on the strobe's trailing edge, so a late data change is not missed.
    wire logic strobe = |i_async_pin[1:0];

    initial begin
        o_word = 16'h0;
        o_panel = 1'b0;
    end

    always @(negedge strobe) begin
        if (!i_panel0_select || !i_panel1_select) begin
            o_word <= i_async_data;
            o_panel <= !i_panel1_select;
        end
    end
endmodule

/* File: bench/testbench.sv */
// Self-checking bench for the display control signal generator.
`timescale 1ns/1ps

module testbench;
    import dcsg_pkg::*;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic lclk = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [23:0] pix_in = 24'h0;
    logic pix_req;
    logic [23:0] pix_out;
    logic disp_clk;
    logic [6:0] sync_pin;
    logic sel0;
    logic sel1;
    logic [6:0] async_pin;
    logic [15:0] async_data;
    logic [15:0] cap_word;
    logic cap_panel;
    int bad_count = 0;
    int samples_checked = 0;
    int cnt [0:18];
    logic [7:0] cfg_a [0:9] = '{8'h08, 8'h0c, 8'h20, 8'h24, 8'h40, 8'h44, 8'h4c, 8'h60, 8'h64,
        8'h7c};
    logic [31:0] cfg_d [0:9] = '{32'h0003000f, 32'h00000701, 32'h0, 32'h1, 32'h00030001,
        32'h00040000, 32'h80040002, 32'h00040000, 32'h00040000, 32'h800e0000};
    logic [31:0] aw [0:1] = '{32'h0081a5c3, 32'h00023c5a};

    dcsg_top dcsg_top_i (.i_mclk(i_mclk), .i_reset(i_reset), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
        .i_display_interface_clock(lclk), .i_pixel_data(pix_in), .o_pixel_req(pix_req),
        .o_pixel_data(pix_out), .o_disp_clk(disp_clk), .o_sync_pin(sync_pin),
        .o_panel0_select(sel0), .o_panel1_select(sel1), .o_async_pin(async_pin),
        .o_async_data(async_data));

    dcsg_panel_model dcsg_panel_model_i (.i_panel0_select(sel0), .i_panel1_select(sel1),
        .i_async_pin(async_pin), .i_async_data(async_data), .o_word(cap_word),
        .o_panel(cap_panel));

    initial begin
        forever #12.5 i_mclk = ~i_mclk;
    end

    // The link clock is offset so that its edges never line up with the bus clock.
    initial begin
        #7;
        forever #62.5 lclk = ~lclk;
    end

    always @(posedge lclk) begin
        pix_in <= pix_in + 24'h1;
    end

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge i_mclk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do begin
            @(posedge i_mclk);
        end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge i_mclk);
        end while (hreadyout !== 1'b1);
        q = hrdata;
        chk("hresp", {31'h0, HRESP_OKAY}, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk("register", exp, q);
    endtask

    // Polls one status bit; a bounded count keeps a stuck flag from hanging the run.
    task automatic poll(input int b, input logic v);
        logic [31:0] q;
        int t;
        t = 0;
        do begin
            ahb(1'b0, ADDR_STATUS, 32'h0, q);
            t++;
        end while (q[b] !== v && t < 200);
        chk("status bit", {31'h0, v}, {31'h0, q[b]});
    endtask

    function automatic void sample();
        cnt[0] += int'(disp_clk === 1'b1);
        for (int j = 0; j < 7; j++) begin
            cnt[1 + j] += int'(sync_pin[j] === 1'b1);
            cnt[8 + j] += int'(async_pin[j] === 1'b1);
        end
        cnt[15] += int'(sel0 === 1'b0);
        cnt[16] += int'(sel1 === 1'b0);
    endfunction

    // Counts high half periods of each output, low ones for the panel selects, over n link clocks, mid-phase.
    task automatic measure(input int n);
        logic [23:0] last;
        foreach (cnt[j]) cnt[j] = 0;
        // Step past a link edge so that a word loaded on it is not counted as a change.
        #1;
        last = pix_out;
        repeat (n) begin
            @(posedge lclk);
            #30;
            cnt[17] += int'(pix_req === 1'b1);
            cnt[18] += int'(pix_out !== last);
            last = pix_out;
            sample();
            @(negedge lclk);
            #30;
            sample();
        end
    endtask

    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (80) @(posedge i_mclk);
        i_reset <= 1'b0;
        rd(ADDR_TIMING, 32'h00ff01ff);
        rd(ADDR_ACCESS, 32'h00000701);
        rd(ADDR_STATUS, 32'h0);
        rd(8'hfc, 32'h0);
        for (int k = 0; k < 10; k++) begin
            wr(cfg_a[k], cfg_d[k]);
        end
        rd(8'h44, 32'h00040000);
        wr(ADDR_CTRL, 32'h2);
        poll(STAT_PEND_BIT, 1'b0);
        wr(ADDR_CTRL, 32'h1);
        poll(STAT_RUN_BIT, 1'b1);
        repeat (4) @(posedge lclk);
        measure(64);
        chk("pixel clock halves", 32'd64, 32'(cnt[0]));
        chk("sync pin1 halves", 32'd16, 32'(cnt[1]));
        chk("sync pin2 halves", 32'd0, 32'(cnt[2]));
        chk("frame mode pin halves", 32'd32, 32'(cnt[3]));
        for (int j = 4; j < 8; j++) begin
            chk("idle sync pin halves", 32'd0, 32'(cnt[j]));
        end
        chk("pixel requests", 32'd32, 32'(cnt[17]));
        chk("pixel data changes", 32'd32, 32'(cnt[18]));
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_ASYNC, aw[k]);
            measure(24);
            for (int j = 10; j < 15; j++) begin
                chk("idle async pin halves", 32'd0, 32'(cnt[j]));
            end
            chk("async data", {16'h0, aw[k][15:0]}, {16'h0, async_data});
            chk("flagged pin halves", 32'd4, 32'(cnt[8 + k]));
            chk("unflagged pin halves", 32'd0, 32'(cnt[9 - k]));
            chk("addressed select", 32'd14, 32'(cnt[16 - k]));
            chk("other select", 32'd0, 32'(cnt[15 + k]));
            chk("panel word", {16'h0, aw[k][15:0]}, {16'h0, cap_word});
            chk("panel index", 32'(1 - k), {31'h0, cap_panel});
            poll(STAT_ABUSY_BIT, 1'b0);
        end
        print_verdict();
    end
endmodule

/* File: logic/dcsg_pkg.sv */
// Package of constants and types for the display control signal generator.
package dcsg_pkg;

    // Register byte offsets.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_TIMING = 8'h08;
    localparam logic [7:0] ADDR_ACCESS = 8'h0c;
    localparam logic [7:0] ADDR_ASYNC = 8'h10;
    // Banks of eight registers, selected by address bits 7:5, indexed by bits 4:2.
    localparam logic [2:0] BANK_SG_POS = 3'h1;
    localparam logic [2:0] BANK_SG_EDGE = 3'h2;
    localparam logic [2:0] BANK_AG = 3'h3;

    // Field positions.
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_APPLY_BIT = 1;
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_ABUSY_BIT = 1;
    localparam int STAT_RUN_BIT = 2;
    localparam int TIMING_FRAME_LSB = 16;
    localparam int ACCESS_ALEN_LSB = 8;
    localparam int ASYNC_FLAGS_LSB = 16;
    localparam int ASYNC_PANEL_BIT = 23;
    localparam int EDGE_DOWN_LSB = 16;
    localparam int EDGE_MODE_BIT = 31;
    localparam int AG_DOWN_LSB = 16;
    localparam int AG_INV_BIT = 31;

    // Reset values; every length field holds the length minus one.
    localparam logic [11:0] RST_LINE_LEN = 12'h1ff;
    localparam logic [11:0] RST_FRAME_LINES = 12'h0ff;
    localparam logic [3:0] RST_ACC_LEN = 4'h1;
    localparam logic [7:0] RST_ASYNC_LEN = 8'h07;

    // AHB-Lite codes.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Index of the generator that shapes both panel selects.
    localparam int AG_SEL_IDX = 7;

    typedef struct packed {
        logic [12:0] off;
        logic [12:0] up;
        logic [12:0] down;
        logic frame_mode;
    } dcsg_sgen_t;

    typedef struct packed {
        logic [8:0] up;
        logic [8:0] down;
        logic inv;
    } dcsg_agen_t;

    typedef struct packed {
        logic [11:0] line_len;
        logic [11:0] frame_lines;
        logic [3:0] acc_len;
        logic [7:0] async_len;
        dcsg_sgen_t [7:0] sg;
        dcsg_agen_t [7:0] ag;
    } dcsg_cfg_t;

    typedef struct packed {
        logic [15:0] data;
        logic [6:0] flags;
        logic panel;
    } dcsg_aword_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } dcsg_ahb_ph_t;

    typedef struct packed {
        dcsg_cfg_t live;
        dcsg_cfg_t shadow;
        logic sync_en;
        logic cfg_req;
        dcsg_aword_t aword;
        logic a_req;
        logic [1:0] cfg_ack_s;
        logic [1:0] a_ack_s;
        logic [1:0] run_s;
        dcsg_ahb_ph_t ph;
        logic [31:0] rdata;
    } dcsg_bus_st_t;

    typedef struct packed {
        dcsg_cfg_t cfg;
        logic [1:0] en_s;
        logic [1:0] cfg_req_s;
        logic cfg_ack;
        logic [1:0] a_req_s;
        logic a_ack;
        logic run;
        logic [11:0] lpos;
        logic [3:0] acnt;
        logic [11:0] line;
        logic [23:0] pix;
        logic [7:0] s_hi;
        logic [7:0] s_lo;
        logic busy;
        logic [7:0] acnt2;
        dcsg_aword_t word;
        logic [15:0] adata;
        logic [8:0] a_hi;
        logic [8:0] a_lo;
    } dcsg_disp_st_t;

    function automatic dcsg_cfg_t dcsg_default_cfg();
        dcsg_cfg_t c;
        c = '0;
        c.line_len = RST_LINE_LEN;
        c.frame_lines = RST_FRAME_LINES;
        c.acc_len = RST_ACC_LEN;
        c.async_len = RST_ASYNC_LEN;
        return c;
    endfunction

endpackage

/* File: logic/dcsg_top.sv */
// Display control signal generator: register slave, synchronous and asynchronous generators.
//
// Overview of operation
// R1: Line and frame events come from a start point on the display interface clock.
// R2: Sync controls rise and fall at programmed points, half-clock resolution.
// R3: One dedicated output carries the base pixel clock for the panel.
// R4: Seven general sync pins carry hsync, vsync, active flag or any waveform.
// R5: Async controls change with each data word, gated by its flags.
// R6: Two separate panel selects address one of two displays.
// R7: Seven general async pins serve as write, read, register select or others.
// R8: Each new async data word creates a fresh async start point.
// R9: Async generators toggle at programmed half-clock points from that start.
// R10: Panel gets pixel clock, hsync, vsync and active flag beside pixel data.
// R11: Each sync control is placed by offset plus up and down values.
// R12: Each sync access lasts a whole number of interface clocks.
// R13: Pixel data timing is fixed to the start point, never shifted.
// R14: The pixel data bus is output only.
// R15: Up and down counting restarts at every start point.
`timescale 1ns/1ps

module dcsg_top
    import dcsg_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_display_interface_clock,
    input wire logic [23:0] i_pixel_data,
    output logic o_pixel_req,
    output logic [23:0] o_pixel_data,
    output logic o_disp_clk,
    output logic [6:0] o_sync_pin,
    output logic o_panel0_select,
    output logic o_panel1_select,
    output logic [6:0] o_async_pin,
    output logic [15:0] o_async_data
);

    dcsg_bus_st_t b;
    dcsg_bus_st_t next_b;
    dcsg_disp_st_t d;
    dcsg_disp_st_t next_d;
    logic [1:0] drst_s;
    logic drst;
    logic cfg_pend;
    logic a_busy;
    logic [7:0] sync_lvl;
    logic [8:0] async_lvl;

    // High while half index h lies in [up, down).
    function automatic logic dcsg_lvl(logic [13:0] h, logic [13:0] up_pt, logic [13:0] dn_pt);
        return (h >= up_pt) && (h < dn_pt);
    endfunction

    function automatic logic [31:0] dcsg_read(dcsg_bus_st_t s, logic [7:0] a, logic pend,
                                              logic abusy);
        logic [31:0] r;
        logic [2:0] i;
        r = '0;
        i = a[4:2];
        case (a[7:5])
            BANK_SG_POS: r[12:0] = s.live.sg[i].off;
            BANK_SG_EDGE: begin
                r[12:0] = s.live.sg[i].up;
                r[EDGE_DOWN_LSB +: 13] = s.live.sg[i].down;
                r[EDGE_MODE_BIT] = s.live.sg[i].frame_mode;
            end
            BANK_AG: begin
                r[8:0] = s.live.ag[i].up;
                r[AG_DOWN_LSB +: 9] = s.live.ag[i].down;
                r[AG_INV_BIT] = s.live.ag[i].inv;
            end
            default: begin
                case (a)
                    ADDR_CTRL: r[CTRL_EN_BIT] = s.sync_en;
                    ADDR_STATUS: begin
                        r[STAT_PEND_BIT] = pend;
                        r[STAT_ABUSY_BIT] = abusy;
                        r[STAT_RUN_BIT] = s.run_s[1];
                    end
                    ADDR_TIMING: begin
                        r[11:0] = s.live.line_len;
                        r[TIMING_FRAME_LSB +: 12] = s.live.frame_lines;
                    end
                    ADDR_ACCESS: begin
                        r[3:0] = s.live.acc_len;
                        r[ACCESS_ALEN_LSB +: 8] = s.live.async_len;
                    end
                    ADDR_ASYNC: begin
                        r[15:0] = s.aword.data;
                        r[ASYNC_FLAGS_LSB +: 7] = s.aword.flags;
                        r[ASYNC_PANEL_BIT] = s.aword.panel;
                    end
                    default: r = '0;
                endcase
            end
        endcase
        return r;
    endfunction

    // Bus clock domain: register file and the sending side of both handshakes.
    assign cfg_pend = b.cfg_req != b.cfg_ack_s[1];
    assign a_busy = b.a_req != b.a_ack_s[1];

    always_comb begin
        logic [2:0] idx;
        idx = b.ph.addr[4:2];
        next_b = b;
        next_b.cfg_ack_s = {b.cfg_ack_s[0], d.cfg_ack};
        next_b.a_ack_s = {b.a_ack_s[0], d.a_ack};
        next_b.run_s = {b.run_s[0], d.run};
        if (b.ph.valid && b.ph.write) begin
            case (b.ph.addr[7:5])
                BANK_SG_POS: next_b.live.sg[idx].off = i_hwdata[12:0]; // R11
                BANK_SG_EDGE: begin
                    next_b.live.sg[idx].up = i_hwdata[12:0];
                    next_b.live.sg[idx].down = i_hwdata[EDGE_DOWN_LSB +: 13];
                    next_b.live.sg[idx].frame_mode = i_hwdata[EDGE_MODE_BIT];
                end
                BANK_AG: begin
                    next_b.live.ag[idx].up = i_hwdata[8:0];
                    next_b.live.ag[idx].down = i_hwdata[AG_DOWN_LSB +: 9];
                    next_b.live.ag[idx].inv = i_hwdata[AG_INV_BIT];
                end
                default: begin
                    case (b.ph.addr)
                        ADDR_CTRL: begin
                            next_b.sync_en = i_hwdata[CTRL_EN_BIT];
                            // Apply is refused while the previous copy is still in flight.
                            if (i_hwdata[CTRL_APPLY_BIT] && !cfg_pend) begin
                                next_b.shadow = b.live;
                                next_b.cfg_req = ~b.cfg_req;
                            end
                        end
                        ADDR_TIMING: begin
                            next_b.live.line_len = i_hwdata[11:0];
                            next_b.live.frame_lines = i_hwdata[TIMING_FRAME_LSB +: 12];
                        end
                        ADDR_ACCESS: begin
                            next_b.live.acc_len = i_hwdata[3:0];
                            next_b.live.async_len = i_hwdata[ACCESS_ALEN_LSB +: 8];
                        end
                        ADDR_ASYNC: begin
                            if (!a_busy) begin
                                next_b.aword.data = i_hwdata[15:0];
                                next_b.aword.flags = i_hwdata[ASYNC_FLAGS_LSB +: 7];
                                next_b.aword.panel = i_hwdata[ASYNC_PANEL_BIT];
                                next_b.a_req = ~b.a_req;
                            end
                        end
                        default: next_b.sync_en = b.sync_en;
                    endcase
                end
            endcase
        end
        next_b.ph.valid = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
        next_b.ph.write = i_hwrite;
        next_b.ph.addr = i_haddr[7:0];
        // Reads see the state after any write in the same cycle, so write-then-read is exact.
        if (next_b.ph.valid && !i_hwrite) begin
            next_b.rdata = dcsg_read(next_b, i_haddr[7:0], next_b.cfg_req != b.cfg_ack_s[1],
                                     next_b.a_req != b.a_ack_s[1]);
        end
        if (i_reset) begin
            next_b = '0;
            next_b.live = dcsg_default_cfg();
            next_b.shadow = dcsg_default_cfg();
        end
    end

    always_ff @(posedge i_mclk) begin
        b <= next_b;
    end

    assign o_hrdata = b.rdata;
    assign o_hreadyout = 1'b1;
    assign o_hresp = HRESP_OKAY;

    // Display clock domain reset, brought over by a two-stage synchroniser.
    always_ff @(posedge i_display_interface_clock) begin
        drst_s <= {drst_s[0], i_reset};
    end
    assign drst = drst_s[1];

    always_comb begin
        logic [13:0] h;
        logic [13:0] h2;
        logic [13:0] up_pt;
        logic [13:0] dn_pt;
        logic [2:0] gi;
        logic gate;
        logic act;
        h = '0;
        h2 = '0;
        up_pt = '0;
        dn_pt = '0;
        gi = '0;
        gate = 1'b0;
        act = 1'b0;
        next_d = d;
        next_d.en_s = {d.en_s[0], b.sync_en};
        next_d.cfg_req_s = {d.cfg_req_s[0], b.cfg_req};
        next_d.a_req_s = {d.a_req_s[0], b.a_req};
        if (d.cfg_req_s[1] != d.cfg_ack) begin
            next_d.cfg = b.shadow;
            next_d.cfg_ack = d.cfg_req_s[1];
        end
        // Line, access and frame counting; every line start is a start point.
        if (!d.en_s[1]) begin
            next_d.run = 1'b0;
            next_d.lpos = '0;
            next_d.acnt = '0;
            next_d.line = '0;
        end else if (!d.run) begin
            next_d.run = 1'b1; // R1
            next_d.lpos = '0;
            next_d.acnt = '0;
            next_d.line = '0;
        end else if (d.lpos == d.cfg.line_len) begin
            next_d.lpos = '0; // R15
            next_d.acnt = '0;
            next_d.line = (d.line == d.cfg.frame_lines) ? '0 : d.line + 12'h001; // R1
        end else begin
            next_d.lpos = d.lpos + 12'h001;
            // An access spans acc_len + 1 whole interface clocks.
            next_d.acnt = (d.acnt == d.cfg.acc_len) ? '0 : d.acnt + 4'h1; // R12
        end
        // Pixel data is only ever loaded at an access start and never delayed.
        o_pixel_req = next_d.run && (next_d.acnt == 4'h0);
        if (o_pixel_req) begin
            next_d.pix = i_pixel_data; // R13
        end
        // Generator 0 is the pixel clock, counted from each access start; 1..7 are general.
        for (int i = 0; i < 8; i++) begin
            if (i == 0) begin
                h = {9'h000, next_d.acnt, 1'b0}; // R3
                h2 = h | 14'h0001;
            end else if (next_d.cfg.sg[i].frame_mode) begin
                h = {1'b0, next_d.line, 1'b0}; // R4
                h2 = h;
            end else begin
                h = {1'b0, next_d.lpos, 1'b0}; // R4
                h2 = h | 14'h0001;
            end
            up_pt = {1'b0, next_d.cfg.sg[i].off} + {1'b0, next_d.cfg.sg[i].up}; // R11
            dn_pt = {1'b0, next_d.cfg.sg[i].off} + {1'b0, next_d.cfg.sg[i].down};
            next_d.s_hi[i] = next_d.run && dcsg_lvl(h, up_pt, dn_pt); // R2
            next_d.s_lo[i] = next_d.run && dcsg_lvl(h2, up_pt, dn_pt); // R2
        end
        // Asynchronous path: one data word per request, with its own start point.
        if (!d.busy && (d.a_req_s[1] != d.a_ack)) begin
            next_d.busy = 1'b1;
            next_d.acnt2 = '0; // R8
            next_d.word = b.aword;
            next_d.adata = b.aword.data; // R5
        end else if (d.busy) begin
            if (d.acnt2 == d.cfg.async_len) begin
                next_d.busy = 1'b0;
                next_d.a_ack = d.a_req_s[1];
            end else begin
                next_d.acnt2 = d.acnt2 + 8'h01;
            end
        end
        for (int i = 0; i < 9; i++) begin
            gi = (i < 7) ? 3'(i) : 3'(AG_SEL_IDX);
            if (i < 7) begin
                gate = next_d.word.flags[i]; // R5 R7
            end else if (i == 7) begin
                gate = !next_d.word.panel; // R6
            end else begin
                gate = next_d.word.panel; // R6
            end
            act = next_d.busy && gate;
            h = {5'h00, next_d.acnt2, 1'b0};
            up_pt = {5'h00, next_d.cfg.ag[gi].up};
            dn_pt = {5'h00, next_d.cfg.ag[gi].down};
            next_d.a_hi[i] = next_d.cfg.ag[gi].inv ^ (act && dcsg_lvl(h, up_pt, dn_pt)); // R9
            next_d.a_lo[i] = next_d.cfg.ag[gi].inv ^
                             (act && dcsg_lvl(h | 14'h0001, up_pt, dn_pt)); // R9
        end
        if (drst) begin
            next_d = '0;
            next_d.cfg = dcsg_default_cfg();
        end
    end

    always_ff @(posedge i_display_interface_clock) begin
        d <= next_d;
    end

    // Half-clock placement: the first half of each interface clock shows the value for the
    // even half step, the second half the odd one. Muxing on the clock level costs a possible
    // glitch at the clock edges, traded for not needing a falling-edge register bank.
    assign sync_lvl = i_display_interface_clock ? d.s_hi : d.s_lo;
    assign async_lvl = i_display_interface_clock ? d.a_hi : d.a_lo;
    assign o_disp_clk = sync_lvl[0]; // R3 R10
    assign o_sync_pin = sync_lvl[7:1]; // R10
    assign o_async_pin = async_lvl[6:0];
    assign o_panel0_select = async_lvl[7];
    assign o_panel1_select = async_lvl[8];
    assign o_pixel_data = d.pix; // R14
    assign o_async_data = d.adata;

    a_line_restart: assert property ( // R15
        @(posedge i_display_interface_clock) disable iff (drst)
        (d.run && d.en_s[1] && d.lpos == d.cfg.line_len) |=> (d.lpos == 12'h000 && d.acnt == 4'h0))
        else $error("counters did not restart at line start");

    a_access_whole: assert property ( // R12
        @(posedge i_display_interface_clock) disable iff (drst)
        (d.run && d.en_s[1] && d.lpos != d.cfg.line_len && d.acnt == d.cfg.acc_len
         && $stable(d.cfg.acc_len)) |=> d.acnt == 4'h0)
        else $error("access did not end after whole clocks");

    a_pix_fixed: assert property ( // R13
        @(posedge i_display_interface_clock) disable iff (drst)
        $changed(d.pix) |-> (d.run && d.acnt == 4'h0))
        else $error("pixel data moved away from access start");

    a_async_start: assert property ( // R8
        @(posedge i_display_interface_clock) disable iff (drst)
        $rose(d.busy) |-> (d.acnt2 == 8'h00 && d.adata == d.word.data))
        else $error("async start point not fresh");

    a_async_end: assert property ( // R9
        @(posedge i_display_interface_clock) disable iff (drst)
        (d.busy && d.acnt2 == d.cfg.async_len && $stable(d.cfg.async_len)) |=> !d.busy)
        else $error("async access length wrong");

    a_flag_gate: assert property ( // R5
        @(posedge i_display_interface_clock) disable iff (drst)
        (!d.busy || !d.word.flags[0]) |-> (d.a_hi[0] == d.cfg.ag[0].inv
                                           && d.a_lo[0] == d.cfg.ag[0].inv))
        else $error("async pin moved without its flag");

    a_select_idle: assert property ( // R6
        @(posedge i_display_interface_clock) disable iff (drst)
        (d.busy && d.word.panel) |-> (d.a_hi[7] == d.cfg.ag[AG_SEL_IDX].inv
                                      && d.a_lo[7] == d.cfg.ag[AG_SEL_IDX].inv))
        else $error("unaddressed panel select moved");

    a_sync_idle: assert property ( // R2
        @(posedge i_display_interface_clock) disable iff (drst)
        !d.en_s[1] ##1 !d.en_s[1] |-> (d.s_hi == 8'h00 && d.s_lo == 8'h00) [*2])
        else $error("sync pins active while stopped");

    a_apply_pend: assert property ( // R1
        @(posedge i_mclk) disable iff (i_reset)
        (b.ph.valid && b.ph.write && b.ph.addr == ADDR_CTRL && i_hwdata[CTRL_APPLY_BIT]
         && !cfg_pend) |=> (cfg_pend && b.shadow == $past(b.live)))
        else $error("apply did not start config transfer");

    c_line_wrap: cover property (
        @(posedge i_display_interface_clock) disable iff (drst)
        d.run && d.lpos == d.cfg.line_len);

    c_frame_wrap: cover property (
        @(posedge i_display_interface_clock) disable iff (drst)
        d.run && d.lpos == d.cfg.line_len && d.line == d.cfg.frame_lines);

    c_async_done: cover property (
        @(posedge i_display_interface_clock) disable iff (drst)
        $fell(d.busy));

endmodule
